//--- logic/lpp_pkg.sv
// Purpose: Shared constants and types of the lane pad and PLL power-down
//          controller.
// Assumes: One clock; classic Wishbone on the software side.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
`default_nettype none
package lpp_pkg;

    // Software-side register map.
    localparam logic [7:0] LPP_REG_CTRL = 8'h00;
    localparam logic [7:0] LPP_REG_CMD = 8'h04;
    localparam logic [7:0] LPP_REG_STATUS = 8'h08;
    localparam logic [7:0] LPP_REG_LAST_PAD = 8'h0c;
    localparam logic [7:0] LPP_REG_LAST_PLL = 8'h10;
    localparam logic [7:0] LPP_CTRL_RESET = 8'h00;

    // Field positions of the command and status registers.
    localparam int LPP_CMD_START = 0;
    localparam int LPP_ST_BUSY = 0;
    localparam int LPP_ST_DONE = 1;
    localparam int LPP_ST_REFUSED = 2;

    // Indirect spaces and indices of the device registers.
    localparam logic LPP_SPACE_PCIE = 1'b0;
    localparam logic LPP_SPACE_MISC = 1'b1;
    localparam logic [7:0] LPP_IDX_PAD = 8'h65;
    localparam logic [7:0] LPP_IDX_PLL = 8'h23;
    localparam logic [7:0] LPP_IDX_PDN = 8'h07;

    // Whole-field lane pad values for the single configuration, and the port masks of dual.
    localparam logic [15:0] LPP_PAD_X2 = 16'hfefe;
    localparam logic [15:0] LPP_PAD_X2_REV = 16'h7f7f;
    localparam logic [15:0] LPP_PAD_ALL = 16'hffff;
    localparam logic [15:0] LPP_MASK_PORT0 = 16'h0f0f;
    localparam logic [15:0] LPP_MASK_PORT1 = 16'hf0f0;

    // Nibble values written into both nibbles of one dual-mode port.
    localparam logic [3:0] LPP_NIB_X4 = 4'hc;
    localparam logic [3:0] LPP_NIB_X4_REV = 4'h3;
    localparam logic [3:0] LPP_NIB_X2 = 4'he;
    localparam logic [3:0] LPP_NIB_X2_REV = 4'h7;
    localparam logic [3:0] LPP_NIB_OFF = 4'hf;

    // PLL force bits: 0 first PLL, 1 second PLL, 2 and 3 their buffers.
    localparam int LPP_PLL_FIRST = 0;
    localparam logic [3:0] LPP_PLL_SECOND_OFF = 4'ha;
    localparam logic [3:0] LPP_PLL_FIRST_OFF = 4'h5;
    localparam logic [3:0] LPP_PLL_ALL_OFF = 4'hf;
    localparam logic [15:0] LPP_GATE_BIT = 16'h0001;

    // Software configuration word, port select in bit 0.
    typedef struct packed {
        logic core_in_use;
        logic always_full_pll;
        logic refclk_missing;
        logic powerdown;
        logic reversal;
        logic width_x4;
        logic dual;
        logic port;
    } lpp_ctrl_t;

    // One masked write towards the device.
    typedef struct packed {
        logic req;
        logic space;
        logic [7:0] index;
        logic [15:0] data;
        logic [15:0] mask;
    } lpp_dev_req_t;

    // Writes derived from one configuration.
    typedef struct packed {
        logic [15:0] pad_data;
        logic [15:0] pad_mask;
        logic [3:0] pll_data;
        logic [3:0] pll_mask;
        logic gate;
        logic refuse;
    } lpp_plan_t;

    typedef enum logic [1:0] {
        LPP_S_IDLE = 2'b00,
        LPP_S_LOAD = 2'b01,
        LPP_S_WAIT_ACK = 2'b10,
        LPP_S_WAIT_REL = 2'b11
    } lpp_state_t;

endpackage
`default_nettype wire

//--- logic/lpp_pin_filter.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs change asynchronously to clk_i.
// Notes:   The output moves only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module lpp_pin_filter #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    if (WIDTH < 1) begin : g_bad_width
        $error("lpp_pin_filter needs WIDTH of at least one");
    end

    // One chain per bit; the first stage feeds only the second.
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta;
        logic sync2;
        logic sync3;
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                meta <= 1'b0;
                sync2 <= 1'b0;
                sync3 <= 1'b0;
                q_o[i] <= 1'b0;
            end else if (ce_i) begin
                meta <= d_i[i];
                sync2 <= meta;
                sync3 <= sync2;
                if (sync2 == sync3) begin
                    q_o[i] <= sync3; // Agreement hides a late settling.
                end
            end
        end
    end

endmodule
`default_nettype wire

//--- logic/lpp_ctrl.sv
// Purpose: Host controller that programs the lane pad force-off field, the
//          PLL power force bits and the transmit clock gate of the first
//          port group from a software configuration word.
// Assumes: The device takes masked writes with a four-phase req/ack
//          handshake; ack arrives from another clock domain.
// Notes:   The list below gives the rules that the plan logic keeps.
// Notes on behaviour
// - x4 dual reversed port 0: nibbles 0x3.
// - x2 single: pads 0xFEFE, second PLL off.
// - x2 dual port 0: nibbles 0xE.
// - x2 single reversed: first PLL off.
// - x2 dual reversed port 0: nibbles 0x7.
// - Single, no device: all PLL bits set.
// - Missing reference clock or variant: PLLs all off.
// - Port 0 full power-down: pads 0xFFFF.
// - Dual port 0 power-down: nibbles 0xF.
// - Never stop first PLL while core runs.
// - x4 dual port 1: nibbles 0xC.
// - x4 dual reversed port 1: nibbles 0x3.
// - x2 dual port 1: nibbles 0xE.
// - x2 dual reversed port 1: nibbles 0x7.
// - Port 1 power-down: nibbles 0xF, PLL 1,3.
// - Missing reference clock: set transmit clock gate.
`timescale 1ns/1ps
`default_nettype none
module lpp_ctrl
    import lpp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output lpp_dev_req_t dev_o,
    input wire logic dev_ack_i
);

    if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
        $error("lpp_ctrl needs ADDR_W between 5 and 8");
    end

    // Software view: 32-bit words at byte
    // offsets, meaning in byte lane 0 (LAST_PAD reads: lanes 0 and 1).
    // A write with sel bit 0 low is acked
    // and otherwise ignored.
    // CTRL 0x00: the configuration word.
    //   bit 0 port select
    //   bit 1 dual configuration
    //   bit 2 four-lane width
    //   bit 3 lane reversal
    //   bit 4 full power-down of the port
    //   bit 5 reference clock missing
    //   bit 6 always stop both PLLs
    //   bit 7 group core is running
    // CMD 0x04: one in bit 0 starts; reads 0.
    // STATUS 0x08: busy, done, refused.
    //   Done and refused are sticky and
    //   cleared by writing one to them.
    // LAST_PAD 0x0c: pad value last sent.
    // LAST_PLL 0x10: PLL value last sent.
    // Unmapped offsets read zero.
    // CTRL may change while a sequence runs;
    // the running one keeps its latched plan,
    // so a change counts at the next start.
    // A narrower bus is zero extended; five
    // bits still reach every register.
    lpp_ctrl_t ctrl;
    lpp_plan_t plan;
    lpp_plan_t next_plan;
    lpp_state_t state;
    logic [3:0] nib;
    logic [2:0] pending;
    logic ack_sync;
    logic done;
    logic refused;
    logic busy;
    logic [15:0] last_pad;
    logic [3:0] last_pll;
    logic [7:0] adr;
    logic access;
    logic wr;
    logic start;

    // While ce_i is low every register here,
    // the ack filter too, keeps its value.
    // A bus access must not straddle a low
    // phase, or its ack would stand longer
    // than one cycle.
    assign adr = 8'(wb_adr_i);
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = access && wb_we_i && wb_sel_i[0];
    assign start = wr && (adr == LPP_REG_CMD) && wb_dat_i[LPP_CMD_START];
    assign busy = (state != LPP_S_IDLE);

    // Two flops would pass a one-cycle
    // glitch; the third stage and the
    // agreement test buy immunity to it.
    // The device ack crosses in through the three-stage filter.
    lpp_pin_filter #(
        .WIDTH(1)
    ) u_ack_filter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(dev_ack_i),
        .q_o(ack_sync)
    );

    // Plan summary:
    //   single x2: pads 0xfefe, second PLL off.
    //   single x2 reversed: pads 0x7f7f,
    //     first PLL off.
    //   single power-down: pads 0xffff and
    //     all four PLL bits.
    //   dual: one nibble into both nibbles
    //     of the chosen port, the other
    //     port masked off and left alone.
    //   missing clock or the always flag:
    //     all PLL bits set.
    // A plan that would stop the first PLL
    // under a running core is refused whole.
    // Trimming it instead would leave pads
    // and PLLs in a mix that no
    // configuration describes.
    // Derive the writes for the current configuration. Single mode serves
    // x2 only; the wider single set-ups are left to other firmware steps.
    always_comb begin
        next_plan = '0;
        case ({ctrl.width_x4, ctrl.reversal})
            2'b00: nib = LPP_NIB_X2;
            2'b01: nib = LPP_NIB_X2_REV;
            2'b10: nib = LPP_NIB_X4;
            default: nib = LPP_NIB_X4_REV;
        endcase
        if (ctrl.powerdown) begin
            nib = LPP_NIB_OFF;
        end
        if (!ctrl.dual) begin
            if (ctrl.port || ctrl.width_x4) begin
                next_plan.refuse = 1'b1;
            end else if (ctrl.powerdown) begin
                next_plan.pad_data = LPP_PAD_ALL;
                next_plan.pad_mask = LPP_PAD_ALL;
                next_plan.pll_data = LPP_PLL_ALL_OFF;
                next_plan.pll_mask = LPP_PLL_ALL_OFF;
            end else if (ctrl.reversal) begin
                next_plan.pad_data = LPP_PAD_X2_REV;
                next_plan.pad_mask = LPP_PAD_ALL;
                next_plan.pll_data = LPP_PLL_FIRST_OFF;
                next_plan.pll_mask = LPP_PLL_FIRST_OFF;
            end else begin
                next_plan.pad_data = LPP_PAD_X2;
                next_plan.pad_mask = LPP_PAD_ALL;
                next_plan.pll_data = LPP_PLL_SECOND_OFF;
                next_plan.pll_mask = LPP_PLL_SECOND_OFF;
            end
        end else begin
            // Both nibbles of the chosen port carry the same value.
            next_plan.pad_data = {nib, nib, nib, nib};
            if (ctrl.port) begin
                next_plan.pad_mask = LPP_MASK_PORT1;
            end else begin
                next_plan.pad_mask = LPP_MASK_PORT0;
            end
            if (ctrl.port && ctrl.powerdown) begin
                next_plan.pll_data = LPP_PLL_SECOND_OFF;
                next_plan.pll_mask = LPP_PLL_SECOND_OFF;
            end
        end
        if (ctrl.refclk_missing || ctrl.always_full_pll) begin
            next_plan.pll_data = LPP_PLL_ALL_OFF;
            next_plan.pll_mask = LPP_PLL_ALL_OFF;
        end
        next_plan.gate = ctrl.refclk_missing;
        // The core is clocked by the first PLL, so stopping it is refused.
        if (ctrl.core_in_use && next_plan.pll_mask[LPP_PLL_FIRST]
                && next_plan.pll_data[LPP_PLL_FIRST]) begin
            next_plan.refuse = 1'b1;
        end
    end

    // Configuration register; a start while busy is ignored.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= lpp_ctrl_t'(LPP_CTRL_RESET);
        end else if (ce_i) begin
            if (wr && adr == LPP_REG_CTRL) begin
                ctrl <= lpp_ctrl_t'(wb_dat_i[7:0]);
            end
        end
    end

    // The taken term excludes the ack cycle,
    // so a master that holds its strobe
    // through the ack is not served twice.
    // Wishbone answer: ack one cycle after the strobe, dropped after one.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= access;
            if (access && !wb_we_i) begin
                case (adr)
                    LPP_REG_CTRL: wb_dat_o <= {24'h00_0000, ctrl};
                    LPP_REG_STATUS: wb_dat_o <= {29'h0, refused, done, busy};
                    LPP_REG_LAST_PAD: wb_dat_o <= {16'h0000, last_pad};
                    LPP_REG_LAST_PLL: wb_dat_o <= {28'h000_0000, last_pll};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // Busy is not stored but decoded from
    // the state, so the two never disagree.
    // Sticky status bits; a hardware set wins over a write-one clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done <= 1'b0;
            refused <= 1'b0;
        end else if (ce_i) begin
            if (wr && adr == LPP_REG_STATUS) begin
                if (wb_dat_i[LPP_ST_DONE]) begin
                    done <= 1'b0;
                end
                if (wb_dat_i[LPP_ST_REFUSED]) begin
                    refused <= 1'b0;
                end
            end
            if (state == LPP_S_LOAD && pending == 3'b000) begin
                done <= 1'b1;
            end
            if (start && !busy && next_plan.refuse) begin
                refused <= 1'b1;
            end
        end
    end

    // Handshake states:
    //   LOAD puts one write on the port.
    //   WAIT_ACK holds all fields until the
    //   filtered ack rises, then drops req.
    //   WAIT_REL waits for the ack to fall.
    // The filter costs three to four cycles
    // each way. That is slow but harmless:
    // these are static settings made once,
    // and the four-phase exchange suits a
    // device on any clock. There is no
    // timeout; a silent device leaves busy
    // set, where software can see it.
    // Sequencer: pad field, then PLL bits, then the clock gate, each one
    // a full four-phase handshake so a slow device never loses a write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= LPP_S_IDLE;
            plan <= '0;
            pending <= 3'b000;
            dev_o <= '0;
        end else if (ce_i) begin
            case (state)
                LPP_S_IDLE: begin
                    if (start && !next_plan.refuse) begin
                        plan <= next_plan;
                        pending <= {next_plan.gate,
                                    next_plan.pll_mask != 4'h0,
                                    next_plan.pad_mask != 16'h0000};
                        state <= LPP_S_LOAD;
                    end
                end
                LPP_S_LOAD: begin
                    if (pending[0]) begin
                        dev_o.space <= LPP_SPACE_PCIE;
                        dev_o.index <= LPP_IDX_PAD;
                        dev_o.data <= plan.pad_data;
                        dev_o.mask <= plan.pad_mask;
                        dev_o.req <= 1'b1;
                        pending[0] <= 1'b0;
                        state <= LPP_S_WAIT_ACK;
                    end else if (pending[1]) begin
                        dev_o.space <= LPP_SPACE_MISC;
                        dev_o.index <= LPP_IDX_PLL;
                        dev_o.data <= {12'h000, plan.pll_data};
                        dev_o.mask <= {12'h000, plan.pll_mask};
                        dev_o.req <= 1'b1;
                        pending[1] <= 1'b0;
                        state <= LPP_S_WAIT_ACK;
                    end else if (pending[2]) begin
                        dev_o.space <= LPP_SPACE_MISC;
                        dev_o.index <= LPP_IDX_PDN;
                        dev_o.data <= LPP_GATE_BIT;
                        dev_o.mask <= LPP_GATE_BIT;
                        dev_o.req <= 1'b1;
                        pending[2] <= 1'b0;
                        state <= LPP_S_WAIT_ACK;
                    end else begin
                        state <= LPP_S_IDLE;
                    end
                end
                LPP_S_WAIT_ACK: begin
                    if (ack_sync) begin
                        dev_o.req <= 1'b0;
                        state <= LPP_S_WAIT_REL;
                    end
                end
                LPP_S_WAIT_REL: begin
                    if (!ack_sync) begin
                        state <= LPP_S_LOAD;
                    end
                end
                default: state <= LPP_S_IDLE;
            endcase
        end
    end

    // This follows what was sent, not what
    // the device holds; a lost write is not
    // detected here.
    // Read-back of what was last sent, updated as each pad or PLL write is issued.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_pad <= 16'h0000;
            last_pll <= 4'h0;
        end else if (ce_i && state == LPP_S_LOAD) begin
            if (pending[0]) begin
                last_pad <= plan.pad_data;
            end else if (pending[1]) begin
                last_pll <= plan.pll_data;
            end
        end
    end

endmodule
`default_nettype wire

//--- dv/lpp_ctrl_monitor.sv
// Purpose: Port checker of the power-down controller.
// Assumes: One clock; the device ack may be slow.
// Notes: Bound to the controller from the testbench top.
`timescale 1ns/1ps
`default_nettype none
module lpp_ctrl_monitor
    import lpp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire lpp_dev_req_t dev_o,
    input wire logic dev_ack_i
);
    // Every check shares the one clock and its reset.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // The bus answers one cycle after taking, for one cycle only.
    bus_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
        ce_i |=> wb_ack_o) else $error("bus ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held");
    read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");

    // A device write holds steady until the ack is seen, then drops.
    req_stable_a: assert property (dev_o.req && $past(dev_o.req) |->
        $stable(dev_o)) else $error("request moved");
    req_release_a: assert property (dev_ack_i [*6] |-> !dev_o.req)
        else $error("request not released");
    req_start_a: assert property ($rose(dev_o.req) |-> !dev_ack_i)
        else $error("request over old ack");

    // Only the documented places are written, with legal field shapes.
    index_map_a: assert property (dev_o.req |->
        (dev_o.space == LPP_SPACE_PCIE && dev_o.index == LPP_IDX_PAD) ||
        (dev_o.space == LPP_SPACE_MISC && (dev_o.index == LPP_IDX_PLL ||
        dev_o.index == LPP_IDX_PDN))) else $error("bad index");
    pll_field_a: assert property (dev_o.req && dev_o.index == LPP_IDX_PLL
        |-> dev_o.data[15:4] == 12'h000 && dev_o.mask[15:4] == 12'h000)
        else $error("pll bits out of field");
    dual_nibble_a: assert property (dev_o.req && dev_o.mask == 16'h0f0f
        |-> dev_o.data[3:0] == dev_o.data[11:8])
        else $error("nibbles differ");
    gate_write_a: assert property (dev_o.req && dev_o.index ==
        LPP_IDX_PDN |-> dev_o.data[0] && dev_o.mask[0])
        else $error("gate bit not set");
endmodule
`default_nettype wire

//--- dv/lpp_dev_model.sv
// Purpose: Behavioural device with the pad, PLL and gate registers.
// Assumes: Masked writes under a four-phase req/ack handshake.
// Notes: dly_i sets how long the ack waits, so slow devices are seen.
`timescale 1ns/1ps
`default_nettype none
module lpp_dev_model
    import lpp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire lpp_dev_req_t req_i,
    input wire logic [3:0] dly_i,
    output logic ack_o,
    output logic [15:0] pad_o,
    output logic [3:0] pll_o,
    output logic gate_o
);
    logic [3:0] cnt;
    logic pad_hit;
    logic pll_hit;
    logic pdn_hit;

    // Decode by space and index; anything else is ignored.
    assign pad_hit = req_i.space == LPP_SPACE_PCIE &&
        req_i.index == LPP_IDX_PAD;
    assign pll_hit = req_i.space == LPP_SPACE_MISC &&
        req_i.index == LPP_IDX_PLL;
    assign pdn_hit = req_i.space == LPP_SPACE_MISC &&
        req_i.index == LPP_IDX_PDN;

    // A write lands once as ack rises; set bits stay as levels.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            cnt <= 4'h0;
            pad_o <= 16'h0000;
            pll_o <= 4'h0;
            gate_o <= 1'b0;
        end else if (!req_i.req) begin
            ack_o <= 1'b0;
            cnt <= 4'h0;
        end else if (!ack_o && cnt < dly_i) begin
            cnt <= cnt + 4'h1;
        end else if (!ack_o) begin
            ack_o <= 1'b1;
            if (pad_hit) begin
                pad_o <= (pad_o & ~req_i.mask) | (req_i.data & req_i.mask);
            end
            if (pll_hit) begin
                pll_o <= (pll_o & ~req_i.mask[3:0]) |
                    (req_i.data[3:0] & req_i.mask[3:0]);
            end
            if (pdn_hit && req_i.mask[0]) begin
                gate_o <= req_i.data[0];
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Purpose: Self-checking bench of the power-down controller.
// Assumes: ce_i stays high; the device model answers at random speed.
// Notes: Expected device state is tracked from the masked writes.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lpp_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    lpp_dev_req_t dev;
    logic dev_ack;
    logic [3:0] dly = 4'h0;
    logic [15:0] pad;
    logic [3:0] pll;
    logic gate;
    int err_count = 0;
    int n_tests = 0;
    logic [31:0] rng = 32'd72;
    logic [15:0] e_pad = 16'h0000;
    logic [3:0] e_pll = 4'h0;
    logic e_gate = 1'b0;
    logic [3:0] e_lpll = 4'h0;
    logic [31:0] q;
    lpp_plan_t p;
    logic [7:0] corner [17] = '{8'h00, 8'h08, 8'h10, 8'h0e, 8'h02, 8'h0a,
        8'h12, 8'h07, 8'h0f, 8'h03, 8'h0b, 8'h13, 8'h20, 8'h40, 8'h88,
        8'h06, 8'h01};

    always #20 clk_i = ~clk_i;

    lpp_ctrl i_lpp_ctrl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .dev_o(dev), .dev_ack_i(dev_ack));
    lpp_dev_model i_lpp_dev_model (.clk_i(clk_i), .rst_i(rst_i),
        .req_i(dev), .dly_i(dly), .ack_o(dev_ack), .pad_o(pad),
        .pll_o(pll), .gate_o(gate));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Writes the controller owes for one configuration word.
    function automatic lpp_plan_t plan(input lpp_ctrl_t c);
        lpp_plan_t r;
        logic [3:0] n;
        r = '0;
        n = c.width_x4 ? (c.reversal ? 4'h3 : 4'hc) :
            (c.reversal ? 4'h7 : 4'he);
        n = c.powerdown ? 4'hf : n;
        if (c.dual) begin
            r.pad_mask = c.port ? 16'hf0f0 : 16'h0f0f;
            r.pad_data = {4{n}} & r.pad_mask;
            if (c.port && c.powerdown) begin
                {r.pll_data, r.pll_mask} = 8'haa;
            end
        end else begin
            r.pad_mask = 16'hffff;
            r.pad_data = c.reversal ? 16'h7f7f : 16'hfefe;
            r.pad_data = c.powerdown ? 16'hffff : r.pad_data;
            {r.pll_data, r.pll_mask} = c.reversal ? 8'h55 : 8'haa;
            {r.pll_data, r.pll_mask} = c.powerdown ? 8'hff :
                {r.pll_data, r.pll_mask};
            r.refuse = c.port | c.width_x4;
        end
        if (c.refclk_missing || c.always_full_pll) begin
            {r.pll_data, r.pll_mask} = 8'hff;
        end
        r.gate = c.refclk_missing;
        r.refuse = r.refuse | (c.core_in_use & r.pll_data[0]);
        return r;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic Wishbone cycle; read data lands in q.
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        @(posedge clk_i);
        // Only the watchdog ends a wait for an ack that never comes.
        while (ack !== 1'b1) begin
            @(posedge clk_i);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    // Program one configuration, wait for the verdict, compare state.
    task automatic run(input logic [7:0] c);
        int n;
        p = plan(c);
        rng = xs(rng);
        dly <= rng[3:0];
        wb(1'b1, LPP_REG_CTRL, {24'h0, c}, 4'hf);
        wb(1'b1, LPP_REG_CMD, 32'h1, 4'hf);
        n = 0;
        q = 32'h0;
        while (q[2:1] === 2'b00 && n < 300) begin
            n++;
            wb(1'b0, LPP_REG_STATUS, 32'h0, 4'hf);
        end
        check({29'h0, q[2:0]}, {29'h0, p.refuse, !p.refuse, 1'b0});
        if (!p.refuse) begin
            e_pad = (e_pad & ~p.pad_mask) | p.pad_data;
            e_pll = (e_pll & ~p.pll_mask) | (p.pll_data & p.pll_mask);
            e_gate = e_gate | p.gate;
            wb(1'b0, LPP_REG_LAST_PAD, 32'h0, 4'hf);
            check({16'h0, q[15:0] & p.pad_mask}, {16'h0, p.pad_data});
            if (p.pll_mask != 4'h0) begin
                e_lpll = p.pll_data;
            end
            wb(1'b0, LPP_REG_LAST_PLL, 32'h0, 4'hf);
            check(q, {28'h0, e_lpll});
        end
        check({16'h0, pad}, {16'h0, e_pad});
        check({28'h0, pll}, {28'h0, e_pll});
        check({31'h0, gate}, {31'h0, e_gate});
        wb(1'b1, LPP_REG_STATUS, 32'h6, 4'hf);
    endtask

    task automatic conclude();
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // A hang would stop the run long after the planned traffic.
    initial begin
        #1600000;
        err_count++;
        conclude();
    end

    // Register basics first, then corner words, then random words.
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, LPP_REG_CTRL, 32'h0, 4'hf);
        check(q, 32'h0);
        wb(1'b0, 8'h14, 32'h0, 4'hf);
        check(q, 32'h0);
        wb(1'b1, LPP_REG_CTRL, 32'hff, 4'he);
        wb(1'b0, LPP_REG_CTRL, 32'h0, 4'hf);
        check(q, 32'h0);
        foreach (corner[i]) begin
            run(corner[i]);
        end
        repeat (24) begin
            rng = xs(rng);
            run(rng[15:8]);
        end
        conclude();
    end
endmodule

bind lpp_ctrl lpp_ctrl_monitor #(.ADDR_W(ADDR_W)) i_mon (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .dev_o(dev_o), .dev_ack_i(dev_ack_i));
`default_nettype wire
